/* verilog/cca_timer.sv */
// counter array: shared 16-bit counter, two capture/compare modules, axi4-lite slave
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cca_consts.svh"
module cca_timer #(
    parameter int NMOD = 2
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cpu_idle,
    input wire logic timer0_overflow,
    input wire logic external_count_pin,
    input wire logic [NMOD-1:0] module_pin_in,
    output logic [NMOD-1:0] module_pin,
    output cca_pkg::cca_irq_t irq_req,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import cca_pkg::*;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= `CCA_OFF_PWM1);
    endfunction

    // ---------------- bus slave ----------------
    logic aw_have_q, w_have_q;
    cca_wr_t wr_q;
    logic wr_fire;
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            wr_q <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CCA_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                wr_q.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wr_q.data <= s_axi_wdata;
                wr_q.strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(wr_q.addr) ? `CCA_RESP_OKAY : `CCA_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // only byte lane 0 carries register data
    logic wr_en;
    assign wr_en = wr_fire && wr_q.strb[0];
    function automatic logic wr_at(input logic [7:0] off, input logic [7:0] a, input logic en);
        wr_at = en && (a == off);
    endfunction

    // ---------------- registers ----------------
    logic [7:0] mode_q;
    logic run_q, ovf_q;
    logic [NMOD-1:0] mflag_q;
    logic [15:0] cnt_q;
    logic [7:0] mod_q [NMOD];
    logic [15:0] cap_q [NMOD];
    logic [1:0] pwmx_q [NMOD];

    // ---------------- pin synchronisers ----------------
    logic [1:0] eci_s_q;
    logic eci_prev_q;
    logic [NMOD-1:0] pin_s1_q, pin_s2_q, pin_prev_q;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            eci_s_q <= 2'h0;
            eci_prev_q <= 1'b0;
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_prev_q <= '0;
        end else begin
            eci_s_q <= {eci_s_q[0], external_count_pin};
            eci_prev_q <= eci_s_q[1];
            pin_s1_q <= module_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
        end
    end

    // ---------------- count enable ----------------
    logic [3:0] div_q;
    logic [3:0] div_top;
    logic tick;
    cca_src_t src;
    assign src = cca_src_t'(mode_q[`CCA_B_SRC_HI:`CCA_B_SRC_LO]);
    assign div_top = (src == CCA_SRC_OSC2) ? `CCA_DIV2 : `CCA_DIV12;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            div_q <= 4'h0;
        end else if (div_q >= div_top) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end
    always_comb begin
        unique case (src)
            CCA_SRC_OSC12: tick = (div_q >= div_top);
            CCA_SRC_OSC2: tick = (div_q >= div_top);
            CCA_SRC_T0: tick = timer0_overflow;
            CCA_SRC_PIN: tick = eci_s_q[1] && !eci_prev_q;
        endcase
    end
    logic inc, ovf_evt;
    assign inc = tick && run_q && (mode_q[`CCA_B_IDLE] || !cpu_idle);
    assign ovf_evt = inc && (cnt_q == 16'hFFFF);

    // counter, writable bytewise; a software write wins over the increment
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 16'h0000;
        end else if (wr_at(`CCA_OFF_CNTL, wr_q.addr, wr_en)) begin
            cnt_q[7:0] <= wr_q.data[7:0];
        end else if (wr_at(`CCA_OFF_CNTH, wr_q.addr, wr_en)) begin
            cnt_q[15:8] <= wr_q.data[7:0];
        end else if (inc) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mode_q <= `CCA_RST_BYTE;
        end else if (wr_at(`CCA_OFF_MODE, wr_q.addr, wr_en)) begin
            mode_q <= wr_q.data[7:0] & 8'h87;
        end
    end

    // ---------------- modules ----------------
    logic [NMOD-1:0] match, cap_evt, set_flag;
    logic lo_wrap;
    assign lo_wrap = inc && (cnt_q[7:0] == 8'hFF);
    always_comb begin
        for (int m = 0; m < NMOD; m++) begin
            match[m] = inc && mod_q[m][`CCA_B_ECOM] && (cnt_q + 16'h0001 == cap_q[m]);
            cap_evt[m] = (mod_q[m][`CCA_B_CAPP] && pin_s2_q[m] && !pin_prev_q[m])
                || (mod_q[m][`CCA_B_CAPN] && !pin_s2_q[m] && pin_prev_q[m]);
            set_flag[m] = cap_evt[m] || (match[m] && mod_q[m][`CCA_B_MAT]);
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            run_q <= 1'b0;
            ovf_q <= 1'b0;
            mflag_q <= '0;
        end else begin
            if (wr_at(`CCA_OFF_CTRL, wr_q.addr, wr_en)) begin
                run_q <= wr_q.data[`CCA_B_RUN];
                if (!wr_q.data[`CCA_B_OVF]) begin
                    ovf_q <= 1'b0;
                end
                for (int m = 0; m < NMOD; m++) begin
                    if (!wr_q.data[m]) begin
                        mflag_q[m] <= 1'b0;
                    end
                end
            end
            // hardware set wins over a same-cycle clear
            if (ovf_evt) begin
                ovf_q <= 1'b1;
            end
            for (int m = 0; m < NMOD; m++) begin
                if (set_flag[m]) begin
                    mflag_q[m] <= 1'b1;
                end
            end
        end
    end

    for (genvar g = 0; g < NMOD; g++) begin : g_mod
        logic [7:0] off_l, off_h, off_m, off_p;
        logic [8:0] duty_q;
        assign off_l = `CCA_OFF_CAP0L + 8'(8 * g);
        assign off_h = `CCA_OFF_CAP0H + 8'(8 * g);
        assign off_m = `CCA_OFF_MOD0 + 8'(4 * g);
        assign off_p = `CCA_OFF_PWM0 + 8'(4 * g);
        always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
                cap_q[g] <= 16'h0000;
            end else if (cap_evt[g]) begin
                cap_q[g] <= cnt_q;
            end else if (wr_at(off_l, wr_q.addr, wr_en)) begin
                cap_q[g][7:0] <= wr_q.data[7:0];
            end else if (wr_at(off_h, wr_q.addr, wr_en)) begin
                cap_q[g][15:8] <= wr_q.data[7:0];
            end
        end
        always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
                mod_q[g] <= `CCA_RST_BYTE;
                pwmx_q[g] <= 2'h0;
            end else begin
                if (wr_at(off_m, wr_q.addr, wr_en)) begin
                    mod_q[g] <= wr_q.data[7:0] & 8'h7F;
                end
                if (wr_at(off_p, wr_q.addr, wr_en)) begin
                    pwmx_q[g] <= wr_q.data[1:0];
                end
            end
        end
        // active duty only changes at the low-byte wrap, so no glitch mid-period
        always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
                duty_q <= 9'h000;
            end else if (lo_wrap) begin
                duty_q <= {pwmx_q[g][1], cap_q[g][15:8]};
            end
        end
        logic pwm_on;
        assign pwm_on = mod_q[g][`CCA_B_PWM] && mod_q[g][`CCA_B_ECOM];
        always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
                module_pin[g] <= 1'b1;
            end else if (pwm_on) begin
                module_pin[g] <= ({1'b0, cnt_q[7:0]} >= duty_q);
            end else if (match[g] && mod_q[g][`CCA_B_TOG]) begin
                module_pin[g] <= !module_pin[g];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irq_req <= '0;
        end else begin
            irq_req.irq_overflow <= ovf_q && mode_q[`CCA_B_OVF_IE];
            for (int m = 0; m < NMOD; m++) begin
                irq_req.irq_module[m] <= mflag_q[m] && mod_q[m][`CCA_B_ECCF];
            end
        end
    end

    // ---------------- read channel ----------------
    logic [7:0] rd_byte;
    always_comb begin
        unique case (s_axi_araddr)
            `CCA_OFF_MODE: rd_byte = mode_q;
            `CCA_OFF_CTRL: rd_byte = {ovf_q, run_q, 4'h0, mflag_q[1], mflag_q[0]};
            `CCA_OFF_CNTL: rd_byte = cnt_q[7:0];
            `CCA_OFF_CNTH: rd_byte = cnt_q[15:8];
            `CCA_OFF_CAP0L: rd_byte = cap_q[0][7:0];
            `CCA_OFF_CAP0H: rd_byte = cap_q[0][15:8];
            `CCA_OFF_CAP1L: rd_byte = cap_q[1][7:0];
            `CCA_OFF_CAP1H: rd_byte = cap_q[1][15:8];
            `CCA_OFF_MOD0: rd_byte = mod_q[0];
            `CCA_OFF_MOD1: rd_byte = mod_q[1];
            `CCA_OFF_PWM0: rd_byte = {6'h00, pwmx_q[0]};
            `CCA_OFF_PWM1: rd_byte = {6'h00, pwmx_q[1]};
            default: rd_byte = 8'h00;
        endcase
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CCA_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= mapped(s_axi_araddr) ? `CCA_RESP_OKAY : `CCA_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* verilog/cca_consts.svh */
// constants for the counter array capture/compare block
// Function
// - one 16-bit counter is the shared time base for both modules.
// - idle_run_enable 0 halts counting in idle; 1 keeps counting.
// - source select 00 osc/12, 01 osc/2, 10 timer-0 overflow, 11 pin.
// - overflow interrupt request passes only while overflow_irq_enable is 1.
// - hardware sets overflow_flag on overflow; only writing zero clears it.
// - counting only while run_control is 1; it resets to 0.
// - hardware sets module flag on enabled match or capture; software clears.
// - match when 16-bit counter equals module 16-bit compare register.
// - enabled capture edge copies counter into compare register, sets flag.
// - module flag requests interrupt only when module_irq_enable is 1.
// - toggle bit set inverts module pin latch on every match; the code skips the toggle while pwm and comparator enable are both set.
// - match_flag_enable set lets a match set the module flag.
// - falling bit captures falling, rising bit rising, both either edge.
// - matches evaluated only while comparator_enable is 1; resets 0.
// - pwm plus comparator enable drives pin from 8-bit pwm output.
// - capture modes need an edge bit; all zero means no operation.
// - enable plus match is timer; adding toggle gives high-speed output.
// - pwm output low while counter low byte below 9-bit duty, else high.
// - duty reloads from high shadow when counter low byte wraps to zero.
`ifndef CCA_CONSTS_SVH
`define CCA_CONSTS_SVH
`define CCA_OFF_MODE 8'h00
`define CCA_OFF_CTRL 8'h04
`define CCA_OFF_CNTL 8'h08
`define CCA_OFF_CNTH 8'h0C
`define CCA_OFF_CAP0L 8'h10
`define CCA_OFF_CAP0H 8'h14
`define CCA_OFF_CAP1L 8'h18
`define CCA_OFF_CAP1H 8'h1C
`define CCA_OFF_MOD0 8'h20
`define CCA_OFF_MOD1 8'h24
`define CCA_OFF_PWM0 8'h28
`define CCA_OFF_PWM1 8'h2C
`define CCA_B_IDLE 7
`define CCA_B_SRC_HI 2
`define CCA_B_SRC_LO 1
`define CCA_B_OVF_IE 0
`define CCA_B_OVF 7
`define CCA_B_RUN 6
`define CCA_B_ECOM 6
`define CCA_B_CAPP 5
`define CCA_B_CAPN 4
`define CCA_B_MAT 3
`define CCA_B_TOG 2
`define CCA_B_PWM 1
`define CCA_B_ECCF 0
`define CCA_RST_BYTE 8'h00
`define CCA_DIV12 4'hB
`define CCA_DIV2 4'h1
`define CCA_RESP_OKAY 2'h0
`define CCA_RESP_SLVERR 2'h2
`endif

/* verilog/cca_pkg.sv */
// types for the counter array capture/compare block
package cca_pkg;
    typedef enum logic [1:0] {
        CCA_SRC_OSC12,
        CCA_SRC_OSC2,
        CCA_SRC_T0,
        CCA_SRC_PIN
    } cca_src_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } cca_wr_t;
    typedef struct packed {
        logic irq_overflow;
        logic [1:0] irq_module;
    } cca_irq_t;
endpackage

/* verif/cca_timer_monitor.sv */
// checker for the counter array bus answers and pin reset state
`timescale 1ns/1ps
`default_nettype none
module cca_timer_monitor #(
    parameter int NMOD = 2
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [NMOD-1:0] module_pin,
    input wire cca_pkg::cca_irq_t irq_req,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import cca_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence ar_bad;
        s_axi_arvalid && s_axi_arready && (s_axi_araddr > 8'h2C || s_axi_araddr[1:0] != 2'h0);
    endsequence
    sequence err_word;
        s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endsequence
    reset_quiet_a:
        assert property ($past(sys_rst) |-> irq_req == 3'h0 && module_pin == {NMOD{1'h1}}) else $error("reset state");
    bresp_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write answer dropped");
    rdata_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read moved");
    byte_read_a:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
    read_busy_a:
        assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken during read");
    aw_pulse_a:
        assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
    aw_answer_a:
        assert property (s_axi_awvalid && !s_axi_bvalid |-> ##[0:4] s_axi_awready) else $error("awready late");
    bad_read_a:
        assert property (ar_bad |=> err_word) else $error("unmapped read answered");
endmodule
bind cca_timer cca_timer_monitor #(.NMOD(NMOD)) mon (.*);
`default_nettype wire

/* verif/cca_pin_model.sv */
// far side: count pin and capture pins, each inverted on request
`timescale 1ns/1ps
`default_nettype none
module cca_pin_model (
    input wire logic clk_sys,
    input wire logic [2:0] flip,
    output var logic count_pin,
    output var logic [1:0] cap_pin
);
    // pins are plain levels with no pull; they start low
    initial begin
        count_pin = 1'h0;
        cap_pin = 2'h0;
    end
    always @(posedge clk_sys) begin
        count_pin <= count_pin ^ flip[0];
        cap_pin <= cap_pin ^ flip[2:1];
    end
endmodule
`default_nettype wire

/* verif/cca_timer_test.sv */
// self-checking bench for the counter array timer
`timescale 1ns/1ps
`default_nettype none
`include "cca_consts.svh"
module cca_timer_test;
    import cca_pkg::*;
    localparam logic [1:0] RESP_OK = `CCA_RESP_OKAY;
    localparam logic [1:0] RESP_ER = `CCA_RESP_SLVERR;
    logic clk_sys, sys_rst = 1'h1, cpu_idle = 1'h0, timer0_overflow = 1'h0, external_count_pin;
    logic [1:0] module_pin_in, module_pin, s_axi_bresp, s_axi_rresp;
    logic [2:0] flip = 3'h0, s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    cca_irq_t irq_req;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, rv;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [33:0] rd_q[$];
    logic [1:0] wr_q[$];
    int n_errors = 0, tests_run = 0;
    cca_pin_model pins (.clk_sys(clk_sys), .flip(flip), .count_pin(external_count_pin), .cap_pin(module_pin_in));
    cca_timer #(.NMOD(2)) DUT (.*);
    initial begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [33:0] seen, input logic [33:0] want);
        tests_run++;
        if (seen !== want) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic conclude;
        $display("errors=%0d checks=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // each bus task starts on a fresh edge so a release never meets a new request
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OK, input logic [3:0] s = 4'hF);
        logic fa, fw;
        fa = 1'h0;
        fw = 1'h0;
        @(posedge clk_sys);
        wr_q.push_back(r);
        s_axi_awaddr <= a;
        s_axi_awprot <= 3'($urandom);
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(fa && fw)) begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) begin
                fa = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                fw = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge clk_sys); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OK);
        @(posedge clk_sys);
        rd_q.push_back({r, 24'h0, d});
        s_axi_araddr <= a;
        s_axi_arprot <= 3'($urandom);
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk_sys); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
    endtask
    task automatic tick(input int n);
        @(posedge clk_sys);
        repeat (n) begin
            timer0_overflow <= 1'h1;
            @(posedge clk_sys);
            timer0_overflow <= 1'h0;
            @(posedge clk_sys);
        end
    endtask
    // eight edges leave room for the two-stage pin synchroniser
    task automatic pin_edge(input logic [2:0] f);
        flip <= f;
        @(posedge clk_sys);
        flip <= 3'h0;
        repeat (8) @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
        if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp), 34'(wr_q.pop_front()));
    end
    initial begin
        #500_000;
        n_errors++;
        conclude();
    end
    initial begin
        void'($urandom(32'hBB3A));
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'h0;
        for (int a = 0; a <= 8'h2C; a += 4) rd(8'(a), `CCA_RST_BYTE);
        rd(8'h30, 8'h00, RESP_ER);
        rd(8'h02, 8'h00, RESP_ER);
        wr(8'h31, 8'h55, RESP_ER);
        rv = 8'($urandom);
        wr(`CCA_OFF_CAP0L, rv);
        wr(`CCA_OFF_CAP0L, ~rv, RESP_OK, 4'h0);
        rd(`CCA_OFF_CAP0L, rv);
        wr(`CCA_OFF_MODE, 8'h04);
        tick(3);
        rd(`CCA_OFF_CNTL, 8'h00);
        wr(`CCA_OFF_CTRL, 8'h40);
        tick(3);
        rd(`CCA_OFF_CNTL, 8'h03);
        cpu_idle <= 1'h1;
        tick(2);
        rd(`CCA_OFF_CNTL, 8'h03);
        wr(`CCA_OFF_MODE, 8'h84);
        tick(2);
        rd(`CCA_OFF_CNTL, 8'h05);
        cpu_idle <= 1'h0;
        wr(`CCA_OFF_MODE, 8'h06);
        repeat (6) pin_edge(3'h1);
        rd(`CCA_OFF_CNTL, 8'h08);
        wr(`CCA_OFF_CTRL, 8'h00);
        wr(`CCA_OFF_MODE, 8'h04);
        wr(`CCA_OFF_CNTH, 8'hFF);
        wr(`CCA_OFF_CNTL, 8'hFF);
        wr(`CCA_OFF_CTRL, 8'h40);
        tick(1);
        rd(`CCA_OFF_CNTH, 8'h00);
        rd(`CCA_OFF_CTRL, 8'hC0);
        chk(irq_req, 3'h0);
        wr(`CCA_OFF_MODE, 8'h05);
        @(negedge clk_sys);
        chk(irq_req, 3'h4);
        wr(`CCA_OFF_CTRL, 8'hC0);
        rd(`CCA_OFF_CTRL, 8'hC0);
        wr(`CCA_OFF_CTRL, 8'h40);
        rd(`CCA_OFF_CTRL, 8'h40);
        wr(`CCA_OFF_CAP0L, 8'h05);
        wr(`CCA_OFF_MOD0, 8'h4D);
        wr(`CCA_OFF_CAP1L, 8'h05);
        wr(`CCA_OFF_MOD1, 8'h40);
        tick(5);
        rd(`CCA_OFF_CTRL, 8'h41);
        chk(module_pin, 2'h2);
        chk(irq_req, 3'h1);
        wr(`CCA_OFF_CTRL, 8'h00);
        wr(`CCA_OFF_CNTH, 8'h12);
        wr(`CCA_OFF_CNTL, 8'h34);
        wr(`CCA_OFF_MOD1, 8'h10);
        pin_edge(3'h4);
        rd(`CCA_OFF_CAP1L, 8'h05);
        wr(`CCA_OFF_CNTL, 8'h56);
        pin_edge(3'h4);
        rd(`CCA_OFF_CAP1L, 8'h56);
        rd(`CCA_OFF_CAP1H, 8'h12);
        rd(`CCA_OFF_CTRL, 8'h02);
        wr(`CCA_OFF_MOD1, 8'h30);
        wr(`CCA_OFF_CNTL, 8'h78);
        pin_edge(3'h4);
        rd(`CCA_OFF_CAP1L, 8'h78);
        wr(`CCA_OFF_CAP0H, 8'h80);
        wr(`CCA_OFF_MOD0, 8'h42);
        wr(`CCA_OFF_CNTL, 8'hFE);
        wr(`CCA_OFF_CTRL, 8'h40);
        // pin is registered from the counter, so look a half cycle later
        @(negedge clk_sys);
        chk(module_pin, 2'h3);
        tick(2);
        @(negedge clk_sys);
        chk(module_pin, 2'h2);
        wr(`CCA_OFF_CTRL, 8'h00);
        wr(`CCA_OFF_CNTL, 8'h90);
        @(negedge clk_sys);
        chk(module_pin, 2'h3);
        @(posedge clk_sys);
        conclude();
    end
endmodule
`default_nettype wire
